//--- src/core_regs_pkg.sv
package core_regs_pkg;
  // register and word widths
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int EXT_W = 20;
  // condition code bit positions
  localparam int CC_CARRY = 0;
  localparam int CC_OVFL = 1;
  localparam int CC_ZERO = 2;
  localparam int CC_NEG = 3;
  localparam int CC_IMASK = 4;
  localparam int CC_HALF = 5;
  localparam int CC_XMASK = 6;
  localparam int CC_STOPDIS = 7;
  // reset value of the condition code word: s, x, i set
  localparam logic [7:0] CC_RESET = 8'hd0;
  // reset values of the other registers
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // register select codes
  typedef enum logic [2:0] {
    SEL_A = 3'h0,
    SEL_B = 3'h1,
    SEL_D = 3'h2,
    SEL_X = 3'h3,
    SEL_Y = 3'h4,
    SEL_SP = 3'h5,
    SEL_PC = 3'h6,
    SEL_CC = 3'h7
  } reg_sel_t;
  // index base codes
  typedef enum logic [1:0] {
    BASE_X = 2'h0,
    BASE_Y = 2'h1,
    BASE_SP = 2'h2,
    BASE_PC = 2'h3
  } base_sel_t;
  // offset kinds
  typedef enum logic [2:0] {
    OFS_5 = 3'h0,
    OFS_9 = 3'h1,
    OFS_16 = 3'h2,
    OFS_ACC_A = 3'h3,
    OFS_ACC_B = 3'h4,
    OFS_ACC_D = 3'h5,
    OFS_AUTO = 3'h6
  } ofs_kind_t;
  // reset sequence states, gray coded
  typedef enum logic [1:0] {
    ST_VEC_HI = 2'b00,
    ST_VEC_LO = 2'b01,
    ST_RUN = 2'b11
  } rst_state_t;
  // instruction queue depth in bytes
  localparam int QUEUE_DEPTH = 4;
  localparam int QUEUE_MIN = 3;
endpackage

//--- src/index_adder.sv
`timescale 1ns/1ps
`default_nettype none
// adds base and sign or zero extended offset
module index_adder #(
  parameter int OFS_W = 16
) (
  // operands
  input wire logic [15:0] base_in,
  input wire logic [OFS_W-1:0] offset_in,
  input wire logic signed_in,
  // sum
  output logic [15:0] sum_out
);
  // extended offset
  logic [15:0] ext_ofs;
  // extension chosen at elaboration, so no select runs past the offset width
  if (OFS_W >= 16) begin : g_full
    assign ext_ofs = offset_in[15:0];
  end else begin : g_ext
    // fill bit is the offset sign only for signed offsets
    assign ext_ofs = {{(16-OFS_W){signed_in & offset_in[OFS_W-1]}}, offset_in};
  end
  // modulo 16-bit sum
  assign sum_out = base_in + ext_ofs;
endmodule
`default_nettype wire

//--- src/cpu_programming_model_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] two separate 8-bit accumulators a and b
// [RULE2] d is a concatenated with b
// [RULE3] address is index plus constant or accumulator
// [RULE4] stack pointer marks last used stack byte
// [RULE5] stack pointer usable in all indexed modes
// [RULE6] program counter holds next instruction address
// [RULE7] program counter barred from auto increment modes
// [RULE8] condition word: five flags, x, i, stop disable
// [RULE9] half carry for bcd, others for branches
// [RULE10] reset fetches vector, sets x, i, s
// [RULE11] words stored high byte at lower address
// [RULE12] bytes at any address, no alignment
// [RULE13] queue keeps three code bytes ready
// [RULE14] odd length instructions consume bytes, no padding
// [RULE15] 16-bit datapath, 20-bit extended register
// [RULE16] bit, byte, word, fraction, address data
// [RULE17] registers reached by execution only, 16-bit
module cpu_programming_model_regs #(
  parameter logic [15:0] RESET_VECTOR_ADDR = 16'hfffe
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register write port from the sequencer
  input wire logic wr_en_in,
  input wire logic [2:0] wr_sel_in,
  input wire logic [15:0] wr_data_in,
  // register read port
  input wire logic [2:0] rd_sel_in,
  output logic [15:0] rd_data_out,
  // flag update from the alu
  input wire logic flag_we_in,
  input wire logic [4:0] flag_mask_in,
  input wire logic [4:0] flag_val_in,
  // branch condition lookup
  input wire logic [3:0] cond_in,
  output logic cond_true_out,
  // extended math register
  input wire logic ext_we_in,
  input wire logic [19:0] ext_data_in,
  output logic [19:0] ext_out,
  // stack push and pull, one word per request
  input wire logic push_in,
  input wire logic pull_in,
  output logic [15:0] stack_addr_out,
  // indexed address generation
  input wire logic [1:0] base_sel_in,
  input wire logic [2:0] ofs_kind_in,
  input wire logic [15:0] ofs_in,
  input wire logic auto_pre_in,
  input wire logic idx_go_in,
  output logic [15:0] ea_out,
  output logic idx_illegal_out,
  // memory byte port for vector fetch and code fill
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic mem_ack_in,
  input wire logic [7:0] mem_data_in,
  // code queue to the sequencer
  input wire logic [1:0] consume_in,
  input wire logic insn_start_in,
  output logic [23:0] code_bytes_out,
  output logic queue_ready_out,
  // state
  output logic running_out,
  output logic [7:0] ccw_out
);
  // architectural registers
  logic [7:0] acc_a_q;
  logic [7:0] acc_b_q;
  logic [15:0] index_x_q;
  logic [15:0] index_y_q;
  logic [15:0] stack_pointer_q;
  logic [15:0] prog_counter_q;
  logic [7:0] condition_code_word_q;
  logic [19:0] ext_q;
  // reset sequencer
  core_regs_pkg::rst_state_t state_q;
  logic [7:0] vec_hi_q;
  // code queue storage
  logic [7:0] queue_q [core_regs_pkg::QUEUE_DEPTH];
  logic [2:0] count_q;
  logic [15:0] fetch_addr_q;
  // helpers
  logic [15:0] acc_d;
  logic [15:0] base;
  logic [15:0] sum5;
  logic [15:0] sum9;
  logic [15:0] sum16;
  logic [15:0] sum_a;
  logic [15:0] sum_b;
  logic [15:0] sum_d;
  logic [15:0] sum_auto;
  logic [4:0] auto_ofs;
  logic idx_auto;
  logic fill;
  logic [2:0] used;
  logic pc_write;
  logic [2:0] count_d;

  // double accumulator view
  assign acc_d = {acc_a_q, acc_b_q}; // RULE2
  assign running_out = (state_q == core_regs_pkg::ST_RUN);
  assign ccw_out = condition_code_word_q;
  assign ext_out = ext_q;
  assign pc_write = wr_en_in && (wr_sel_in == core_regs_pkg::SEL_PC);

  // accumulators, independent bytes or a word pair
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_a_q <= core_regs_pkg::BYTE_RESET;
      acc_b_q <= core_regs_pkg::BYTE_RESET;
    end else if (wr_en_in) begin
      unique case (wr_sel_in)
        core_regs_pkg::SEL_A: acc_a_q <= wr_data_in[7:0]; // RULE1
        core_regs_pkg::SEL_B: acc_b_q <= wr_data_in[7:0]; // RULE1
        core_regs_pkg::SEL_D: begin
          acc_a_q <= wr_data_in[15:8]; // RULE2
          acc_b_q <= wr_data_in[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // index registers, written or auto stepped
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      index_x_q <= core_regs_pkg::WORD_RESET;
      index_y_q <= core_regs_pkg::WORD_RESET;
    end else if (wr_en_in && wr_sel_in == core_regs_pkg::SEL_X) begin
      index_x_q <= wr_data_in; // RULE17
    end else if (wr_en_in && wr_sel_in == core_regs_pkg::SEL_Y) begin
      index_y_q <= wr_data_in; // RULE17
    end else if (idx_go_in && idx_auto && base_sel_in == core_regs_pkg::BASE_X) begin
      index_x_q <= sum_auto;
    end else if (idx_go_in && idx_auto && base_sel_in == core_regs_pkg::BASE_Y) begin
      index_y_q <= sum_auto;
    end
  end

  // stack pointer: push pre-decrements by a word, pull post-increments
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_pointer_q <= core_regs_pkg::WORD_RESET;
    end else if (wr_en_in && wr_sel_in == core_regs_pkg::SEL_SP) begin
      stack_pointer_q <= wr_data_in;
    end else if (push_in) begin
      stack_pointer_q <= stack_pointer_q - 16'h0002; // RULE4
    end else if (pull_in) begin
      stack_pointer_q <= stack_pointer_q + 16'h0002; // RULE4
    end else if (idx_go_in && idx_auto && base_sel_in == core_regs_pkg::BASE_SP) begin
      stack_pointer_q <= sum_auto; // RULE5
    end
  end

  // stack address: new top for push, current top for pull
  always_comb begin
    if (push_in) begin
      stack_addr_out = stack_pointer_q - 16'h0002; // RULE4
    end else begin
      stack_addr_out = stack_pointer_q;
    end
  end

  // condition code word with set-on-reset masks
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      condition_code_word_q <= core_regs_pkg::CC_RESET; // RULE10
    end else if (wr_en_in && wr_sel_in == core_regs_pkg::SEL_CC) begin
      condition_code_word_q <= wr_data_in[7:0]; // RULE8
    end else if (flag_we_in) begin
      // flag order: c v z n h
      if (flag_mask_in[0]) condition_code_word_q[core_regs_pkg::CC_CARRY] <= flag_val_in[0];
      if (flag_mask_in[1]) condition_code_word_q[core_regs_pkg::CC_OVFL] <= flag_val_in[1];
      if (flag_mask_in[2]) condition_code_word_q[core_regs_pkg::CC_ZERO] <= flag_val_in[2];
      if (flag_mask_in[3]) condition_code_word_q[core_regs_pkg::CC_NEG] <= flag_val_in[3];
      if (flag_mask_in[4]) condition_code_word_q[core_regs_pkg::CC_HALF] <= flag_val_in[4];
    end
  end

  // branch conditions from n z v c only, half carry excluded
  always_comb begin
    logic c;
    logic v;
    logic z;
    logic n;
    c = condition_code_word_q[core_regs_pkg::CC_CARRY];
    v = condition_code_word_q[core_regs_pkg::CC_OVFL];
    z = condition_code_word_q[core_regs_pkg::CC_ZERO];
    n = condition_code_word_q[core_regs_pkg::CC_NEG];
    unique case (cond_in[3:1]) // RULE9
      3'h0: cond_true_out = 1'b1;
      3'h1: cond_true_out = !(c || z);
      3'h2: cond_true_out = !c;
      3'h3: cond_true_out = !z;
      3'h4: cond_true_out = !v;
      3'h5: cond_true_out = !n;
      3'h6: cond_true_out = !(n ^ v);
      default: cond_true_out = !((n ^ v) || z);
    endcase
    if (cond_in[0]) cond_true_out = !cond_true_out;
  end

  // wide register for extended math
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_q <= 20'h00000;
    end else if (ext_we_in) begin
      ext_q <= ext_data_in; // RULE15
    end
  end

  // base select, program counter allowed
  always_comb begin
    unique case (base_sel_in)
      core_regs_pkg::BASE_X: base = index_x_q;
      core_regs_pkg::BASE_Y: base = index_y_q;
      core_regs_pkg::BASE_SP: base = stack_pointer_q; // RULE5
      default: base = prog_counter_q; // RULE7
    endcase
  end

  // offset adders, one per offset kind
  index_adder #(.OFS_W(5)) u_add5 (.base_in(base), .offset_in(ofs_in[4:0]),
    .signed_in(1'b1), .sum_out(sum5));
  index_adder #(.OFS_W(9)) u_add9 (.base_in(base), .offset_in(ofs_in[8:0]),
    .signed_in(1'b1), .sum_out(sum9));
  index_adder #(.OFS_W(16)) u_add16 (.base_in(base), .offset_in(ofs_in),
    .signed_in(1'b1), .sum_out(sum16));
  index_adder #(.OFS_W(8)) u_adda (.base_in(base), .offset_in(acc_a_q),
    .signed_in(1'b0), .sum_out(sum_a));
  index_adder #(.OFS_W(8)) u_addb (.base_in(base), .offset_in(acc_b_q),
    .signed_in(1'b0), .sum_out(sum_b));
  index_adder #(.OFS_W(16)) u_addd (.base_in(base), .offset_in(acc_d),
    .signed_in(1'b0), .sum_out(sum_d));
  // auto step: ofs_in[3:0] signed, -8..-1 or +1..+8 (0 means +8)
  // code zero would otherwise step by nothing, so it is mapped to +8 here
  assign auto_ofs = (ofs_in[3:0] == 4'h0) ? 5'h08 : {ofs_in[3], ofs_in[3:0]}; // RULE5
  index_adder #(.OFS_W(5)) u_addauto (.base_in(base), .offset_in(auto_ofs),
    .signed_in(1'b1), .sum_out(sum_auto));
  assign idx_auto = (ofs_kind_in == core_regs_pkg::OFS_AUTO) &&
    (base_sel_in != core_regs_pkg::BASE_PC); // RULE7

  // effective address mux
  always_comb begin
    idx_illegal_out = 1'b0;
    unique case (ofs_kind_in) // RULE3
      core_regs_pkg::OFS_5: ea_out = sum5;
      core_regs_pkg::OFS_9: ea_out = sum9;
      core_regs_pkg::OFS_16: ea_out = sum16;
      core_regs_pkg::OFS_ACC_A: ea_out = sum_a;
      core_regs_pkg::OFS_ACC_B: ea_out = sum_b;
      core_regs_pkg::OFS_ACC_D: ea_out = sum_d;
      core_regs_pkg::OFS_AUTO: begin
        ea_out = auto_pre_in ? sum_auto : base;
        idx_illegal_out = (base_sel_in == core_regs_pkg::BASE_PC); // RULE7
      end
      default: begin
        ea_out = base;
        idx_illegal_out = 1'b1;
      end
    endcase
  end

  // reset: vector high byte then low byte, big endian
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= core_regs_pkg::ST_VEC_HI;
      vec_hi_q <= core_regs_pkg::BYTE_RESET;
    end else if (mem_ack_in) begin
      unique case (state_q) // RULE10
        core_regs_pkg::ST_VEC_HI: begin
          vec_hi_q <= mem_data_in; // RULE11
          state_q <= core_regs_pkg::ST_VEC_LO;
        end
        core_regs_pkg::ST_VEC_LO: state_q <= core_regs_pkg::ST_RUN;
        core_regs_pkg::ST_RUN: state_q <= core_regs_pkg::ST_RUN;
        default: state_q <= core_regs_pkg::ST_VEC_HI;
      endcase
    end
  end

  // program counter: vector load, write, or advance by bytes used
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_counter_q <= core_regs_pkg::WORD_RESET;
    end else if (state_q == core_regs_pkg::ST_VEC_LO && mem_ack_in) begin
      prog_counter_q <= {vec_hi_q, mem_data_in}; // RULE10
    end else if (pc_write) begin
      prog_counter_q <= wr_data_in; // RULE6
    end else if (running_out) begin
      prog_counter_q <= prog_counter_q + {13'h0000, used}; // RULE14
    end
  end

  // fetch byte addresses, any alignment
  assign fill = running_out && !pc_write && (count_q < 3'(core_regs_pkg::QUEUE_DEPTH));
  assign used = (consume_in <= count_q[1:0] || count_q[2]) ? {1'b0, consume_in} : 3'h0;
  always_comb begin
    unique case (state_q)
      core_regs_pkg::ST_VEC_HI: mem_addr_out = RESET_VECTOR_ADDR;
      core_regs_pkg::ST_VEC_LO: mem_addr_out = RESET_VECTOR_ADDR + 16'h0001;
      default: mem_addr_out = fetch_addr_q; // RULE12
    endcase
  end
  assign mem_rd_out = !running_out || fill;

  // code queue: shift out consumed bytes, append fetched byte
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= 3'h0;
      fetch_addr_q <= core_regs_pkg::WORD_RESET;
      for (int i = 0; i < core_regs_pkg::QUEUE_DEPTH; i++) queue_q[i] <= 8'h00;
    end else if (state_q == core_regs_pkg::ST_VEC_LO && mem_ack_in) begin
      count_q <= 3'h0;
      fetch_addr_q <= {vec_hi_q, mem_data_in};
    end else if (pc_write) begin
      count_q <= 3'h0; // flush on jump
      fetch_addr_q <= wr_data_in;
    end else if (running_out) begin
      for (int i = 0; i < core_regs_pkg::QUEUE_DEPTH; i++) begin
        if (i + int'(used) < core_regs_pkg::QUEUE_DEPTH) begin
          queue_q[i] <= queue_q[i + int'(used)]; // RULE14
        end
      end
      if (fill && mem_ack_in) begin
        queue_q[2'(count_q - used)] <= mem_data_in; // RULE13
        fetch_addr_q <= fetch_addr_q + 16'h0001; // RULE12
      end
      count_q <= count_d;
    end
  end
  assign count_d = count_q - used + {2'h0, fill && mem_ack_in};

  // three bytes offered at instruction start
  assign code_bytes_out = {queue_q[0], queue_q[1], queue_q[2]};
  assign queue_ready_out = running_out && (count_q >= 3'(core_regs_pkg::QUEUE_MIN)); // RULE13

  // register read mux, execution access only
  always_comb begin
    unique case (rd_sel_in) // RULE17
      core_regs_pkg::SEL_A: rd_data_out = {8'h00, acc_a_q};
      core_regs_pkg::SEL_B: rd_data_out = {8'h00, acc_b_q};
      core_regs_pkg::SEL_D: rd_data_out = acc_d; // RULE16
      core_regs_pkg::SEL_X: rd_data_out = index_x_q;
      core_regs_pkg::SEL_Y: rd_data_out = index_y_q;
      core_regs_pkg::SEL_SP: rd_data_out = stack_pointer_q;
      core_regs_pkg::SEL_PC: rd_data_out = prog_counter_q;
      default: rd_data_out = {8'h00, condition_code_word_q};
    endcase
  end

  // assertions
  property p_reset_masks;
    @(posedge clk_in) $rose(reset_n_in) |-> condition_code_word_q[7:6] == 2'b11 &&
      condition_code_word_q[4];
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("masks not set at reset"); // RULE10
  property p_pc_auto_illegal;
    @(posedge clk_in) disable iff (!reset_n_in)
      (ofs_kind_in == 3'h6 && base_sel_in == 2'h3) |-> idx_illegal_out;
  endproperty
  a_pc_auto_illegal: assert property (p_pc_auto_illegal) else $error("pc auto not flagged"); // RULE7
  property p_push;
    @(posedge clk_in) disable iff (!reset_n_in)
      (push_in && !wr_en_in) |=> stack_pointer_q == $past(stack_pointer_q) - 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("push step wrong"); // RULE4
  property p_dword;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_en_in && wr_sel_in == 3'h2) |=> {acc_a_q, acc_b_q} == $past(wr_data_in);
  endproperty
  a_dword: assert property (p_dword) else $error("d write wrong"); // RULE2
  property p_acc_ofs;
    @(posedge clk_in) disable iff (!reset_n_in)
      ofs_kind_in == 3'h4 |-> ea_out == base + {8'h00, acc_b_q};
  endproperty
  a_acc_ofs: assert property (p_acc_ofs) else $error("acc offset wrong"); // RULE3
  property p_ready;
    @(posedge clk_in) disable iff (!reset_n_in)
      (running_out && $fell(queue_ready_out)) |->
      ($past(consume_in) != 2'h0) || $past(pc_write);
  endproperty
  a_ready: assert property (p_ready) else $error("queue drained without use"); // RULE13
  property p_start_ready;
    @(posedge clk_in) disable iff (!reset_n_in)
      (running_out && insn_start_in) |-> queue_ready_out;
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("start with short queue"); // RULE13
  property p_vector;
    @(posedge clk_in) disable iff (!reset_n_in)
      (state_q == core_regs_pkg::ST_VEC_LO && mem_ack_in) |=>
      prog_counter_q == {vec_hi_q, $past(mem_data_in)};
  endproperty
  a_vector: assert property (p_vector) else $error("vector load wrong"); // RULE11
  property p_pc_step;
    @(posedge clk_in) disable iff (!reset_n_in)
      (running_out && !pc_write) |=> prog_counter_q == $past(prog_counter_q) + {13'h0, $past(used)};
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong"); // RULE14
endmodule
`default_nettype wire

//--- verif/mem_image_pkg.sv
package mem_image_pkg;
  // where the start vector lives and what it holds
  localparam logic [15:0] VEC_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_VAL = 16'h1234;
  // byte image of the whole space, vector stored high byte first
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    if (a == VEC_ADDR) begin
      return VEC_VAL[15:8];
    end
    if (a == VEC_ADDR + 16'h0001) begin
      return VEC_VAL[7:0];
    end
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
endpackage

//--- verif/code_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// byte memory answering vector fetch and code fill
module code_mem_model (
  // clock and pacing
  input wire logic clk_in,
  input wire logic slow_in,
  // byte request from the core
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_rd_in,
  // byte answer
  output logic mem_ack_out,
  output logic [7:0] mem_data_out
);
  // alternates answers in slow mode
  logic toggle_q = 1'b0;
  // answer settles after the falling edge so the core samples it at the rising edge
  initial begin
    mem_ack_out = 1'b0;
    mem_data_out = 8'h00;
    forever begin
      @(negedge clk_in);
      #1;
      toggle_q = ~toggle_q;
      // any byte address is served, no alignment
      if (mem_rd_in && (!slow_in || toggle_q)) begin
        mem_ack_out = 1'b1;
        mem_data_out = mem_image_pkg::byte_at(mem_addr_in);
      end else begin
        // stale byte inverted on the bus each idle cycle
        mem_ack_out = 1'b0;
        mem_data_out = ~mem_data_out;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/cpu_programming_model_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_programming_model_regs_tb;
  // drive side
  logic clk, rst_n, wr_en, flag_we, ext_we, push, pull, pre, go, ins_start, slow;
  logic [2:0] wr_sel, rd_sel, kind;
  logic [15:0] wr_data, ofs, rd_data, stack_addr, ea, mem_addr;
  logic [4:0] fmask, fval;
  logic [3:0] cond;
  logic [19:0] ext_data, ext;
  logic [1:0] base, consume;
  logic [7:0] mem_data, ccw;
  logic [23:0] code;
  logic cond_true, illegal, mem_rd, mem_ack, qready, running;
  int fail_count = 0;
  int cmp_count = 0;
  // x, i and stop disable bits after reset
  localparam logic [7:0] MASKS = (8'h01 << core_regs_pkg::CC_XMASK)
    | (8'h01 << core_regs_pkg::CC_IMASK) | (8'h01 << core_regs_pkg::CC_STOPDIS);
  // branch outcome for codes 0..7 with c=1 v=0 z=1 n=0
  localparam logic [7:0] COND_BASE = 8'h71;
  // device under test
  cpu_programming_model_regs #(.RESET_VECTOR_ADDR(mem_image_pkg::VEC_ADDR)) uut (
    .clk_in(clk), .reset_n_in(rst_n), .wr_en_in(wr_en), .wr_sel_in(wr_sel),
    .wr_data_in(wr_data), .rd_sel_in(rd_sel), .rd_data_out(rd_data),
    .flag_we_in(flag_we), .flag_mask_in(fmask), .flag_val_in(fval), .cond_in(cond),
    .cond_true_out(cond_true), .ext_we_in(ext_we), .ext_data_in(ext_data), .ext_out(ext),
    .push_in(push), .pull_in(pull), .stack_addr_out(stack_addr), .base_sel_in(base),
    .ofs_kind_in(kind), .ofs_in(ofs), .auto_pre_in(pre), .idx_go_in(go), .ea_out(ea),
    .idx_illegal_out(illegal), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
    .mem_ack_in(mem_ack), .mem_data_in(mem_data), .consume_in(consume),
    .insn_start_in(ins_start), .code_bytes_out(code), .queue_ready_out(qready),
    .running_out(running), .ccw_out(ccw));
  // far side memory
  code_mem_model mem_i (.clk_in(clk), .slow_in(slow), .mem_addr_in(mem_addr),
    .mem_rd_in(mem_rd), .mem_ack_out(mem_ack), .mem_data_out(mem_data));
  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register write, strobe held over one rising edge
  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // combinational register read
  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    @(negedge clk);
    rd_sel = sel;
    #1;
    chk(24'(rd_data), 24'(exp));
  endtask
  // indexed address request, optional step pulse
  task automatic idx(input logic [1:0] b, input logic [2:0] k, input logic [15:0] o,
      input logic p, input logic g, input logic [15:0] e, input logic ill);
    @(negedge clk);
    base = b;
    kind = k;
    ofs = o;
    pre = p;
    go = g;
    #1;
    chk(24'(ea), 24'(e));
    chk(24'(illegal), 24'(ill));
    @(negedge clk);
    go = 1'b0;
  endtask
  // wait for three code bytes, then compare them with memory from pc
  task automatic q_expect(input logic [15:0] p);
    int n;
    n = 0;
    while (qready !== 1'b1 && n < 60) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk(24'(qready), 24'h1);
    chk(code, {mem_image_pkg::byte_at(p), mem_image_pkg::byte_at(p + 16'h1),
      mem_image_pkg::byte_at(p + 16'h2)});
  endtask
  // take the bytes of one instruction out of the queue
  task automatic take(input logic [1:0] nb);
    @(negedge clk);
    consume = nb;
    ins_start = 1'b1;
    @(negedge clk);
    consume = 2'd0;
    ins_start = 1'b0;
  endtask
  // reset values, then vector fetch to running
  task automatic reset_check();
    int n;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    #1;
    chk(24'(ccw), 24'(MASKS));
    chk(24'({mem_rd, running}), 24'h2);
    chk(24'(mem_addr), 24'(mem_image_pkg::VEC_ADDR));
    rd(core_regs_pkg::SEL_X, 16'h0000);
    rst_n = 1'b1;
    n = 0;
    while (running !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk(24'(running), 24'h1);
    rd(core_regs_pkg::SEL_PC, mem_image_pkg::VEC_VAL);
  endtask
  // accumulators alone and paired
  task automatic acc_check();
    wr(core_regs_pkg::SEL_A, 16'h00a5);
    wr(core_regs_pkg::SEL_B, 16'h003c);
    rd(core_regs_pkg::SEL_D, 16'ha53c);
    wr(core_regs_pkg::SEL_D, 16'h1357);
    rd(core_regs_pkg::SEL_A, 16'h0013);
    rd(core_regs_pkg::SEL_B, 16'h0057);
  endtask
  // every offset kind, pc and stack pointer as base
  task automatic index_check();
    wr(core_regs_pkg::SEL_X, 16'h8000);
    wr(core_regs_pkg::SEL_SP, 16'h2000);
    idx(2'h0, core_regs_pkg::OFS_5, 16'h001f, 1'b0, 1'b0, 16'h7fff, 1'b0);
    idx(2'h0, core_regs_pkg::OFS_9, 16'h0100, 1'b0, 1'b0, 16'h7f00, 1'b0);
    idx(2'h1, core_regs_pkg::OFS_16, 16'h1234, 1'b0, 1'b0, 16'h1234, 1'b0);
    idx(2'h0, core_regs_pkg::OFS_ACC_A, 16'h0, 1'b0, 1'b0, 16'h8013, 1'b0);
    idx(2'h0, core_regs_pkg::OFS_ACC_B, 16'h0, 1'b0, 1'b0, 16'h8057, 1'b0);
    idx(2'h0, core_regs_pkg::OFS_ACC_D, 16'h0, 1'b0, 1'b0, 16'h9357, 1'b0);
    idx(2'h3, core_regs_pkg::OFS_16, 16'h0010, 1'b0, 1'b0, 16'h1244, 1'b0);
    idx(2'h3, core_regs_pkg::OFS_AUTO, 16'h0001, 1'b0, 1'b1, 16'h1234, 1'b1);
    rd(core_regs_pkg::SEL_PC, 16'h1234);
    idx(2'h2, core_regs_pkg::OFS_AUTO, 16'h000c, 1'b1, 1'b1, 16'h1ffc, 1'b0);
    rd(core_regs_pkg::SEL_SP, 16'h1ffc);
    idx(2'h2, core_regs_pkg::OFS_AUTO, 16'h0000, 1'b0, 1'b1, 16'h1ffc, 1'b0);
    rd(core_regs_pkg::SEL_SP, 16'h2004);
  endtask
  // push then pull back to back
  task automatic stack_check();
    wr(core_regs_pkg::SEL_SP, 16'h2000);
    @(negedge clk);
    push = 1'b1;
    #1;
    chk(24'(stack_addr), 24'h1ffe);
    @(negedge clk);
    push = 1'b0;
    pull = 1'b1;
    #1;
    chk(24'(stack_addr), 24'h1ffe);
    @(negedge clk);
    pull = 1'b0;
    rd(core_regs_pkg::SEL_SP, 16'h2000);
  endtask
  // flag update keeps masks, every branch code both ways
  task automatic flag_check();
    @(negedge clk);
    flag_we = 1'b1;
    fmask = 5'h1f;
    fval = 5'b10101;
    @(negedge clk);
    flag_we = 1'b0;
    #1;
    chk(24'(ccw), 24'(MASKS | 8'h25));
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      cond = 4'(i);
      #1;
      chk(24'(cond_true), 24'(COND_BASE[i / 2] ^ cond[0]));
    end
    @(negedge clk);
    flag_we = 1'b1;
    fmask = 5'h01;
    fval = 5'h00;
    @(negedge clk);
    flag_we = 1'b0;
    #1;
    chk(24'(ccw), 24'(MASKS | 8'h24));
  endtask
  // main sequence
  initial begin
    {rst_n, wr_en, flag_we, ext_we, push, pull, pre, go, ins_start, slow} = '0;
    {wr_sel, rd_sel, kind, wr_data, ofs, fmask, fval, cond} = '0;
    {ext_data, base, consume} = '0;
    reset_check();
    acc_check();
    index_check();
    stack_check();
    flag_check();
    // wide extended math register
    @(negedge clk);
    ext_we = 1'b1;
    ext_data = 20'habcde;
    @(negedge clk);
    ext_we = 1'b0;
    #1;
    chk(24'(ext), 24'habcde);
    // queue refills with memory stalling, odd lengths, odd target
    slow = 1'b1;
    q_expect(16'h1234);
    take(2'd1);
    rd(core_regs_pkg::SEL_PC, 16'h1235);
    q_expect(16'h1235);
    take(2'd3);
    q_expect(16'h1238);
    wr(core_regs_pkg::SEL_PC, 16'h4001);
    q_expect(16'h4001);
    slow = 1'b0;
    // second reset in mid run
    reset_check();
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
